//--- core/e1_lineunit_ctrl_status_regs.sv
// Purpose: Primary control and status registers of a four-channel E1 line unit
// Assumes: Host port pins and line status arrive asynchronously to ref_clk
// Notes: Host strobes pass two flops; address and data are held during strobes
`timescale 1ns/1ns
`default_nettype none

module e1_lineunit_ctrl_status_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Host port
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_n,
    // Line status
    input wire logic [3:0] signal_loss_state,
    input wire logic [3:0] driver_fault_state,
    input wire logic [3:0] alarm_state,
    // Per-channel controls
    output logic [3:0] digital_loopback,
    output logic [3:0] criteria_etsi,
    output logic [3:0] tx_all_ones,
    output logic [3:0] alarm_insert,
    output logic [3:0] driver_hiz,
    // Monitor selection
    output logic [3:0] monitor_code,
    output logic [2:0] monitor_rx_sel,
    output logic [2:0] monitor_tx_sel,
    // Global controls
    output logic short_protect_enable,
    output logic line_code_ami,
    output logic jitter_buffer_64,
    output logic jitter_bw_high,
    output logic jitter_in_tx,
    output logic jitter_in_rx,
    // Status
    output logic soft_reset_active,
    output logic irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [3:0] los_mask;
        logic [3:0] df_mask;
        logic [3:0] mon_code;
        logic [3:0] digital_loopback_ctrl;
        logic [3:0] loss_criteria_select;
        logic [3:0] auto_all_ones_ctrl;
        logic [3:0] oe;
        logic [3:0] ais_mask;
        logic [6:0] global_config;
        logic [e1_lineunit_pkg::SRST_CNT_W-1:0] srst_cnt;
        logic wr_q;
        logic rd_q;
        logic [7:0] rd_addr;
        logic [7:0] rdata;
    } ctrl_t;

    ctrl_t r_reg;
    ctrl_t r_next;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] nib(input logic [3:0] v);
        nib = {4'h0, v};
    endfunction

    function automatic logic [2:0] point_sel(input logic [3:0] code, input logic tx);
        logic [2:0] sel;
        sel = 3'h0;
        if (code[e1_lineunit_pkg::MON_DIR_BIT] == tx && code[2] == 1'b0 && code[1:0] != 2'b00)
        begin
            sel[code[1:0] - 2'b01] = 1'b1;
        end
        point_sel = sel;
    endfunction

    // ****************************************************************
    // Synchronisers
    // ****************************************************************
    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic [7:0] addr_s;
    logic [7:0] wdata_s;
    logic [3:0] los_s;
    logic [3:0] df_s;
    logic [3:0] ais_s;

    pin_sync #(.W(19), .RST_VAL(19'h70000)) u_host_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .d({host_cs_n, host_rd_n, host_wr_n, host_addr, host_data_in}),
        .q({cs_n_s, rd_n_s, wr_n_s, addr_s, wdata_s})
    );

    pin_sync #(.W(12), .RST_VAL(12'h000)) u_line_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .d({signal_loss_state, driver_fault_state, alarm_state}),
        .q({los_s, df_s, ais_s})
    );

    // ****************************************************************
    // Host access decode
    // ****************************************************************
    logic wr_act;
    logic rd_act;
    logic wr_pulse;
    logic rd_start;
    logic rd_end;
    logic srst_busy;
    logic los_clr;
    logic df_clr;
    logic ais_clr;
    logic [3:0] los_flags;
    logic [3:0] df_flags;
    logic [3:0] ais_flags;

    assign wr_act = !cs_n_s && !wr_n_s;
    assign rd_act = !cs_n_s && !rd_n_s;
    assign wr_pulse = wr_act && !r_reg.wr_q;
    assign rd_start = rd_act && !r_reg.rd_q;
    assign rd_end = !rd_act && r_reg.rd_q;
    assign srst_busy = r_reg.srst_cnt != '0;

    assign los_clr = srst_busy || (rd_end && r_reg.rd_addr == e1_lineunit_pkg::ADDR_LOS_STATE);
    assign df_clr = srst_busy || (rd_end && r_reg.rd_addr == e1_lineunit_pkg::ADDR_DF_STATE);
    assign ais_clr = srst_busy || (rd_end && r_reg.rd_addr == e1_lineunit_pkg::ADDR_ALARM_STATE);

    // ****************************************************************
    // Event flags
    // ****************************************************************
    event_flags #(.N(e1_lineunit_pkg::CHANNELS)) u_los_flags (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .state(los_s),
        .mask(r_reg.los_mask),
        .clr(los_clr),
        .flags(los_flags)
    );

    event_flags #(.N(e1_lineunit_pkg::CHANNELS)) u_df_flags (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .state(df_s),
        .mask(r_reg.df_mask),
        .clr(df_clr),
        .flags(df_flags)
    );

    event_flags #(.N(e1_lineunit_pkg::CHANNELS)) u_ais_flags (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .state(ais_s),
        .mask(r_reg.ais_mask),
        .clr(ais_clr),
        .flags(ais_flags)
    );

    // ****************************************************************
    // Register next state
    // ****************************************************************
    always_comb
    begin
        logic [7:0] rd_val;
        rd_val = e1_lineunit_pkg::UNMAPPED_VALUE;
        r_next = r_reg;
        r_next.wr_q = wr_act;
        r_next.rd_q = rd_act;
        unique case (addr_s)
            e1_lineunit_pkg::ADDR_LOS_STATE: rd_val = nib(los_s);
            e1_lineunit_pkg::ADDR_DF_STATE: rd_val = nib(df_s);
            e1_lineunit_pkg::ADDR_LOS_MASK: rd_val = nib(r_reg.los_mask);
            e1_lineunit_pkg::ADDR_DF_MASK: rd_val = nib(r_reg.df_mask);
            e1_lineunit_pkg::ADDR_LOS_FLAGS: rd_val = nib(los_flags);
            e1_lineunit_pkg::ADDR_DF_FLAGS: rd_val = nib(df_flags);
            e1_lineunit_pkg::ADDR_SOFT_RESET: rd_val = e1_lineunit_pkg::SOFT_RESET_VALUE;
            e1_lineunit_pkg::ADDR_MONITOR: rd_val = nib(r_reg.mon_code);
            e1_lineunit_pkg::ADDR_LOOPBACK: rd_val = nib(r_reg.digital_loopback_ctrl);
            e1_lineunit_pkg::ADDR_CRITERIA: rd_val = nib(r_reg.loss_criteria_select);
            e1_lineunit_pkg::ADDR_AUTO_ONES: rd_val = nib(r_reg.auto_all_ones_ctrl);
            e1_lineunit_pkg::ADDR_GLOBAL: rd_val = {1'b0, r_reg.global_config};
            e1_lineunit_pkg::ADDR_OUT_DISABLE: rd_val = nib(r_reg.oe);
            e1_lineunit_pkg::ADDR_ALARM_STATE: rd_val = nib(ais_s);
            e1_lineunit_pkg::ADDR_ALARM_MASK: rd_val = nib(r_reg.ais_mask);
            e1_lineunit_pkg::ADDR_ALARM_FLAGS: rd_val = nib(ais_flags);
            default: rd_val = e1_lineunit_pkg::UNMAPPED_VALUE;
        endcase
        if (rd_start)
        begin
            r_next.rdata = rd_val;
            r_next.rd_addr = addr_s;
        end
        if (srst_busy)
        begin
            r_next.srst_cnt = r_reg.srst_cnt - e1_lineunit_pkg::SRST_CNT_W'(1);
            r_next.los_mask = e1_lineunit_pkg::NIBBLE_DEFAULT;
            r_next.df_mask = e1_lineunit_pkg::NIBBLE_DEFAULT;
            r_next.mon_code = e1_lineunit_pkg::NIBBLE_DEFAULT;
            r_next.digital_loopback_ctrl = e1_lineunit_pkg::NIBBLE_DEFAULT;
            r_next.loss_criteria_select = e1_lineunit_pkg::NIBBLE_DEFAULT;
            r_next.auto_all_ones_ctrl = e1_lineunit_pkg::NIBBLE_DEFAULT;
            r_next.oe = e1_lineunit_pkg::NIBBLE_DEFAULT;
            r_next.ais_mask = e1_lineunit_pkg::NIBBLE_DEFAULT;
            r_next.global_config = e1_lineunit_pkg::GLOBAL_DEFAULT;
        end
        else if (wr_pulse)
        begin
            unique case (addr_s)
                e1_lineunit_pkg::ADDR_LOS_MASK: r_next.los_mask = wdata_s[3:0];
                e1_lineunit_pkg::ADDR_DF_MASK: r_next.df_mask = wdata_s[3:0];
                e1_lineunit_pkg::ADDR_SOFT_RESET:
                    r_next.srst_cnt =
                        e1_lineunit_pkg::SRST_CNT_W'(e1_lineunit_pkg::SOFT_RESET_CYCLES);
                e1_lineunit_pkg::ADDR_MONITOR: r_next.mon_code = wdata_s[3:0];
                e1_lineunit_pkg::ADDR_LOOPBACK: r_next.digital_loopback_ctrl = wdata_s[3:0];
                e1_lineunit_pkg::ADDR_CRITERIA: r_next.loss_criteria_select = wdata_s[3:0];
                e1_lineunit_pkg::ADDR_AUTO_ONES: r_next.auto_all_ones_ctrl = wdata_s[3:0];
                e1_lineunit_pkg::ADDR_GLOBAL: r_next.global_config = wdata_s[6:0];
                e1_lineunit_pkg::ADDR_OUT_DISABLE: r_next.oe = wdata_s[3:0];
                e1_lineunit_pkg::ADDR_ALARM_MASK: r_next.ais_mask = wdata_s[3:0];
                default: r_next.srst_cnt = r_reg.srst_cnt;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign host_data_out = r_reg.rdata;
    assign host_data_oe_n = !r_reg.rd_q;
    assign soft_reset_active = srst_busy;

    assign digital_loopback = r_reg.digital_loopback_ctrl;
    assign criteria_etsi = r_reg.loss_criteria_select;
    assign tx_all_ones = r_reg.auto_all_ones_ctrl & los_s;
    assign alarm_insert = {4{r_reg.global_config[e1_lineunit_pkg::GCF_ALARM_INSERT]}} & los_s;
    assign driver_hiz = r_reg.oe;

    assign monitor_code = r_reg.mon_code;
    assign monitor_rx_sel = point_sel(r_reg.mon_code, 1'b0);
    assign monitor_tx_sel = point_sel(r_reg.mon_code, 1'b1);

    assign short_protect_enable = !r_reg.global_config[e1_lineunit_pkg::GCF_SHORT_DISABLE];
    assign line_code_ami = r_reg.global_config[e1_lineunit_pkg::GCF_LINE_CODE];
    assign jitter_buffer_64 = r_reg.global_config[e1_lineunit_pkg::GCF_JITTER_DEPTH];
    assign jitter_bw_high = r_reg.global_config[e1_lineunit_pkg::GCF_JITTER_BW];
    assign jitter_in_tx = r_reg.global_config[e1_lineunit_pkg::GCF_PATH_HI:e1_lineunit_pkg::GCF_PATH_LO]
        == e1_lineunit_pkg::JA_PATH_TX;
    assign jitter_in_rx = r_reg.global_config[e1_lineunit_pkg::GCF_PATH_HI:e1_lineunit_pkg::GCF_PATH_LO]
        == e1_lineunit_pkg::JA_PATH_RX;

    assign irq = |{los_flags, df_flags, ais_flags};

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_srst_start;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_pulse && !srst_busy && addr_s == e1_lineunit_pkg::ADDR_SOFT_RESET)
            |=> (r_reg.srst_cnt
                == e1_lineunit_pkg::SRST_CNT_W'(e1_lineunit_pkg::SOFT_RESET_CYCLES));
    endproperty
    a_srst_start: assert property (p_srst_start)
        else $error("reset cycle did not start with full count");

    property p_srst_end;
        @(posedge ref_clk) disable iff (!rst_n)
        (r_reg.srst_cnt == e1_lineunit_pkg::SRST_CNT_W'(1)) |=> (!soft_reset_active
            && r_reg.global_config == e1_lineunit_pkg::GLOBAL_DEFAULT
            && r_reg.digital_loopback_ctrl == e1_lineunit_pkg::NIBBLE_DEFAULT
            && r_reg.oe == e1_lineunit_pkg::NIBBLE_DEFAULT && irq == 1'b0);
    endproperty
    a_srst_end: assert property (p_srst_end)
        else $error("registers not at default after reset cycle");

    property p_rs_reads_ff;
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_start && addr_s == e1_lineunit_pkg::ADDR_SOFT_RESET)
            |=> (host_data_out == e1_lineunit_pkg::SOFT_RESET_VALUE);
    endproperty
    a_rs_reads_ff: assert property (p_rs_reads_ff)
        else $error("reset register content changed");

    property p_oe_write;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_pulse && !srst_busy && addr_s == e1_lineunit_pkg::ADDR_OUT_DISABLE)
            |=> (driver_hiz == $past(wdata_s[3:0]));
    endproperty
    a_oe_write: assert property (p_oe_write)
        else $error("output disable write not applied");

    property p_mon_reserved;
        @(posedge ref_clk) disable iff (!rst_n)
        (monitor_code[2] || monitor_code[1:0] == 2'b00)
            |-> (monitor_rx_sel == 3'h0 && monitor_tx_sel == 3'h0);
    endproperty
    a_mon_reserved: assert property (p_mon_reserved)
        else $error("reserved or idle monitor code selected a point");

    property p_all_ones;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(los_s[0]) && r_reg.auto_all_ones_ctrl[0] |-> tx_all_ones[0]
            ##1 (tx_all_ones[0] || !los_s[0] || !r_reg.auto_all_ones_ctrl[0]);
    endproperty
    a_all_ones: assert property (p_all_ones)
        else $error("all ones not sent during loss of signal");

    property p_irq;
        @(posedge ref_clk) disable iff (!rst_n)
        (|ais_flags) |-> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt low while alarm flag set");

    property p_ais_read_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_end && r_reg.rd_addr == e1_lineunit_pkg::ADDR_ALARM_STATE
            && ((ais_s ^ $past(ais_s)) & r_reg.ais_mask) == 4'h0) |=> (ais_flags == 4'h0);
    endproperty
    a_ais_read_clear: assert property (p_ais_read_clear)
        else $error("alarm flags not cleared after alarm read");

endmodule

`default_nettype wire

//--- core/e1_lineunit_pkg.sv
// Purpose: Shared constants for the E1 line unit control and status registers
// Assumes: 20 MHz reference clock, 8-bit host port, four channels
// Notes: Offsets are the host port addresses of the primary bank

package e1_lineunit_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int CHANNELS = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_LOS_STATE = 8'h04;
    localparam logic [7:0] ADDR_DF_STATE = 8'h05;
    localparam logic [7:0] ADDR_LOS_MASK = 8'h06;
    localparam logic [7:0] ADDR_DF_MASK = 8'h07;
    localparam logic [7:0] ADDR_LOS_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_DF_FLAGS = 8'h09;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h0a;
    localparam logic [7:0] ADDR_MONITOR = 8'h0b;
    localparam logic [7:0] ADDR_LOOPBACK = 8'h0c;
    localparam logic [7:0] ADDR_CRITERIA = 8'h0d;
    localparam logic [7:0] ADDR_AUTO_ONES = 8'h0e;
    localparam logic [7:0] ADDR_GLOBAL = 8'h0f;
    localparam logic [7:0] ADDR_OUT_DISABLE = 8'h12;
    localparam logic [7:0] ADDR_ALARM_STATE = 8'h13;
    localparam logic [7:0] ADDR_ALARM_MASK = 8'h14;
    localparam logic [7:0] ADDR_ALARM_FLAGS = 8'h15;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] SOFT_RESET_VALUE = 8'hff;
    localparam logic [3:0] NIBBLE_DEFAULT = 4'h0;
    localparam logic [6:0] GLOBAL_DEFAULT = 7'h00;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

    // ****************************************************************
    // Global configuration fields
    // ****************************************************************
    localparam int GCF_ALARM_INSERT = 6;
    localparam int GCF_SHORT_DISABLE = 5;
    localparam int GCF_LINE_CODE = 4;
    localparam int GCF_JITTER_DEPTH = 3;
    localparam int GCF_JITTER_BW = 2;
    localparam int GCF_PATH_HI = 1;
    localparam int GCF_PATH_LO = 0;
    localparam logic [1:0] JA_PATH_TX = 2'b01;
    localparam logic [1:0] JA_PATH_RX = 2'b11;

    // ****************************************************************
    // Monitor code fields
    // ****************************************************************
    localparam int MON_DIR_BIT = 3;
    localparam int MON_POINTS = 3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int SOFT_RESET_NS = 1000;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SRST_CNT_W = $clog2(SOFT_RESET_CYCLES + 1);

endpackage

//--- core/event_flags.sv
// Purpose: Sticky per-channel change flags with mask and clear
// Assumes: State input already synchronised
// Notes: A new event in the clearing cycle is kept
`timescale 1ns/1ns
`default_nettype none

module event_flags #(
    parameter int N = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Event source
    input wire logic [N-1:0] state,
    input wire logic [N-1:0] mask,
    input wire logic clr,
    // Flags
    output logic [N-1:0] flags
);

    typedef struct packed {
        logic [N-1:0] prev;
        logic [N-1:0] flags;
    } evt_t;

    evt_t r_reg;
    evt_t r_next;
    logic [N-1:0] hit;

    generate
        if (N < 1)
        begin : g_chk
            $error("event_flags needs at least one channel");
        end
    endgenerate

    assign hit = (state ^ r_reg.prev) & mask;

    always_comb
    begin
        r_next = r_reg;
        r_next.prev = state;
        r_next.flags = (clr ? '0 : r_reg.flags) | hit;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign flags = r_reg.flags;

    property p_set_on_change;
        @(posedge ref_clk) disable iff (!rst_n)
        (|hit) |=> ((flags & $past(hit)) == $past(hit));
    endproperty
    a_set_on_change: assert property (p_set_on_change)
        else $error("masked change did not set its flag");

    property p_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        (clr && !(|hit)) |=> (flags == '0);
    endproperty
    a_clear: assert property (p_clear)
        else $error("flags not cleared after clear");

    property p_masked_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (!clr && ((state ^ r_reg.prev) & ~mask) != '0 && !(|hit)) |=> $stable(flags);
    endproperty
    a_masked_hold: assert property (p_masked_hold)
        else $error("masked-off change altered flags");

endmodule

`default_nettype wire

//--- core/pin_sync.sv
// Purpose: Two-stage synchroniser for pins entering the reference clock domain
// Assumes: Inputs are quasi-static relative to the strobes that qualify them
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_t;

    sync_t r_reg;
    sync_t r_next;

    generate
        if (W < 1)
        begin : g_chk
            $error("pin_sync width must be at least one");
        end
    endgenerate

    always_comb
    begin
        r_next.meta = d;
        r_next.stable = r_reg.meta;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg <= {RST_VAL, RST_VAL};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.stable;

endmodule

`default_nettype wire

//--- dv/e1_lineunit_ctrl_status_regs_tb.sv
// Purpose: Self-checking bench for the line unit registers
// Assumes: Host model timing per the port hand-over
// Notes: Line states driven by the bench
`timescale 1ns/1ns
`default_nettype none
module e1_lineunit_ctrl_status_regs_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, rd_n, wr_n, oe_n, spe, ami, j64, jbw, jtx, jrx, sra, irq;
    logic [7:0] addr, din, dout;
    logic [11:0] st = 12'h000;
    logic [3:0] digital_loopback_ctrl, crit, tao, ais_ins, hiz, mcode;
    logic [2:0] rxs, txs;
    int fails = 0;
    int n_compared = 0;
    logic [7:0] ma [3] = '{8'h06, 8'h07, 8'h14};
    logic [7:0] fa [3] = '{8'h08, 8'h09, 8'h15};
    logic [7:0] sa [3] = '{8'h04, 8'h05, 8'h13};
    always #25 ref_clk = ~ref_clk;
    host_model i_host (.ref_clk(ref_clk), .host_cs_n(cs_n), .host_rd_n(rd_n),
        .host_wr_n(wr_n), .host_addr(addr), .host_data_in(din),
        .host_data_out(dout), .host_data_oe_n(oe_n));
    e1_lineunit_ctrl_status_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_addr(addr),
        .host_data_in(din), .host_data_out(dout), .host_data_oe_n(oe_n),
        .signal_loss_state(st[3:0]), .driver_fault_state(st[7:4]),
        .alarm_state(st[11:8]), .digital_loopback(digital_loopback_ctrl), .criteria_etsi(crit),
        .tx_all_ones(tao), .alarm_insert(ais_ins), .driver_hiz(hiz),
        .monitor_code(mcode), .monitor_rx_sel(rxs), .monitor_tx_sel(txs),
        .short_protect_enable(spe), .line_code_ami(ami), .jitter_buffer_64(j64),
        .jitter_bw_high(jbw), .jitter_in_tx(jtx), .jitter_in_rx(jrx),
        .soft_reset_active(sra), .irq(irq));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_host.acc(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        i_host.acc(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic t_ctrl;
        logic [7:0] gw [3] = '{8'h7f, 8'h81, 8'h02};
        logic [7:0] gr [3] = '{8'h7f, 8'h01, 8'h02};
        logic [7:0] go [3] = '{8'h1d, 8'h22, 8'h20};
        logic [2:0] e;
        rc(8'h0a, 8'hff);
        foreach (ma[k]) rc(fa[k], 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            w(8'h0f, gw[i]);
            rc(8'h0f, gr[i]);
            chk({2'h0, spe, ami, j64, jbw, jtx, jrx}, go[i]);
        end
        w(8'h0c, 8'ha5);
        w(8'h0d, 8'h03);
        w(8'h12, 8'h0c);
        chk({digital_loopback_ctrl, crit}, 8'h53);
        chk({4'h0, hiz}, 8'h0c);
        rc(8'h0c, 8'h05);
        for (int c = 0; c < 16; c++)
        begin
            e = (c[2] == 1'b0 && c[1:0] != 2'b00) ? 3'b001 << (c[1:0] - 2'd1) : 3'b000;
            w(8'h0b, c[7:0]);
            chk({mcode, 4'h0}, {c[3:0], 4'h0});
            chk({2'h0, rxs, txs}, c[3] ? {5'h0, e} : {2'h0, e, 3'h0});
        end
    endtask
    task automatic t_events;
        foreach (ma[k])
        begin
            w(ma[k], 8'hf1);
            rc(ma[k], 8'h01);
            @(posedge ref_clk);
            st[4*k] <= 1'b1;
            st[4*k+1] <= 1'b1;
            repeat (5) @(posedge ref_clk);
            chk({7'h0, irq}, 8'h01);
            rc(fa[k], 8'h01);
            rc(sa[k], 8'h03);
            rc(fa[k], 8'h00);
            chk({7'h0, irq}, 8'h00);
            st[4*k] <= 1'b0;
            repeat (5) @(posedge ref_clk);
            rc(fa[k], 8'h01);
            rc(sa[k], 8'h02);
            w(ma[k], 8'h00);
            st[4*k+1] <= 1'b0;
            repeat (5) @(posedge ref_clk);
            rc(fa[k], 8'h00);
        end
    endtask
    task automatic t_auto;
        w(8'h0e, 8'h01);
        w(8'h0f, 8'h40);
        st[3:0] <= 4'h3;
        repeat (4) @(posedge ref_clk);
        chk({tao, ais_ins}, 8'h13);
        st[3:0] <= 4'h0;
        repeat (4) @(posedge ref_clk);
        chk({tao, ais_ins}, 8'h00);
    endtask
    task automatic t_soft;
        w(8'h0c, 8'h0f);
        w(8'h13, 8'hff);
        w(8'h20, 8'hff);
        rc(8'h13, 8'h00);
        rc(8'h20, 8'h00);
        w(8'h0a, 8'h00);
        chk({7'h0, sra}, 8'h01);
        repeat (e1_lineunit_pkg::SOFT_RESET_CYCLES - 7) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({7'h0, sra}, 8'h01);
        @(negedge ref_clk);
        chk({7'h0, sra}, 8'h00);
        rc(8'h0c, 8'h00);
        rc(8'h0f, 8'h00);
        rc(8'h0a, 8'hff);
    endtask
    task automatic end_sim;
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_ctrl();
        t_events();
        t_auto();
        t_soft();
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire

//--- dv/host_model.sv
// Purpose: Host processor model for the strobed register port
// Assumes: Address and data settle two cycles before a strobe
// Notes: Write data bus shows an inverted pattern once released
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // Clock
    input wire logic ref_clk,
    // Host port
    output logic host_cs_n,
    output logic host_rd_n,
    output logic host_wr_n,
    output logic [7:0] host_addr,
    output logic [7:0] host_data_in,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe_n
);
    initial
    begin
        host_cs_n = 1'b1;
        host_rd_n = 1'b1;
        host_wr_n = 1'b1;
        host_addr = 8'h00;
        host_data_in = 8'h00;
    end
    // One access; strobe held four edges, read data taken at the last
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge ref_clk);
        host_addr <= a;
        host_data_in <= d;
        repeat (2) @(posedge ref_clk);
        host_cs_n <= 1'b0;
        host_rd_n <= wr;
        host_wr_n <= !wr;
        repeat (4) @(posedge ref_clk);
        q = (host_data_oe_n === 1'b0) ? host_data_out : 8'hxx;
        host_cs_n <= 1'b1;
        host_rd_n <= 1'b1;
        host_wr_n <= 1'b1;
        host_data_in <= ~d;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire
